// ### shared/kmc_regs.svh
// kmc_regs.svh: timing counts, parameter codes and display tokens of the keypad menu
// assumes a 200 MHz system clock; included by bare name
`ifndef KMC_REGS_SVH
`define KMC_REGS_SVH
`define KMC_CLK_MHZ 200
`define KMC_DEBOUNCE_US 10
`define KMC_DEBOUNCE_CYC (`KMC_DEBOUNCE_US * `KMC_CLK_MHZ)
`define KMC_HOLD_MS 5000
`define KMC_HOLD_CYC (`KMC_HOLD_MS * 1000 * `KMC_CLK_MHZ)
`define KMC_REP_SLOW_MS 200
`define KMC_REP_FAST_MS 50
`define KMC_REP_DELAY_MS 500
`define KMC_REP_FASTER_MS 2000
`define KMC_FLASH_MS 250
`define KMC_FLASH_CYC_DEF (`KMC_FLASH_MS * 1000 * `KMC_CLK_MHZ)
`define KMC_NUM_MODES 4
`define KMC_NUM_MON 16
`define KMC_NUM_PARAMS 16
`define KMC_PASS_DEFAULT 14'h013B
`define KMC_PASS_MAX 14'h270F
`define KMC_PASS_MOTOR 14'h0181
`define KMC_MOTOR_80 14'h0050
`define KMC_MOTOR_90 14'h005A
`define KMC_MOTOR_110 14'h006E
`define KMC_MOTOR_130 14'h0082
`define KMC_PARAM_MAX 14'h270F
`define KMC_IDX_PASS 4'h0
`define KMC_IDX_MOTOR 4'h1
`define KMC_TOKEN_DEF 14'h3FFF
`define KMC_CONFIRM_FLASHES 3'h2
`define KMC_RESTORE_FLASHES 3'h5
`endif

// ### shared/kmc_pkg.sv
// kmc_pkg.sv: types shared by the keypad menu controller
// assumes kmc_regs.svh supplies every number
package kmc_pkg;
  typedef enum logic [2:0] {
    KMC_TOP = 3'h0,
    KMC_MON_SEL = 3'h1,
    KMC_MON_SHOW = 3'h2,
    KMC_PAR_SEL = 3'h3,
    KMC_PAR_SHOW = 3'h4,
    KMC_PAR_EDIT = 3'h5,
    KMC_DEF_TOKEN = 3'h6
  } kmc_state_e;
  typedef logic [13:0] kmc_val_t;
endpackage : kmc_pkg

// ### shared/kmc_key_if.sv
// kmc_key_if.sv: one debounced key's events, from the key conditioner to the menu logic
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface kmc_key_if;
  logic press;
  logic step;
  logic held;
  logic level;
  modport src (output press, output step, output held, output level);
  modport dst (input press, input step, input held, input level);
endinterface : kmc_key_if
`default_nettype wire

// ### verilog/kmc_key.sv
// kmc_key.sv: synchronises, debounces one key and reports press, repeat steps and long hold
// assumes raw key level is asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
`include "kmc_regs.svh"
module kmc_key (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // raw key
  input wire logic key_raw,
  // events
  kmc_key_if.src ev
);
  localparam logic [31:0] DEB = 32'(`KMC_DEBOUNCE_CYC);
  localparam logic [31:0] HOLD = 32'(`KMC_HOLD_CYC);
  localparam logic [31:0] US = 32'(`KMC_CLK_MHZ);
  logic s1_r, s2_r, stable_r;
  logic [31:0] deb_r, held_r, rep_r;

  // two-stage synchroniser
  always_ff @(posedge clk_sys) begin
    s1_r <= srst ? 1'b0 : key_raw;
    s2_r <= srst ? 1'b0 : s1_r;
  end

  // debounce: level accepted once stable for the debounce window
  always_ff @(posedge clk_sys) begin // RULE_19
    if (srst) begin
      deb_r <= '0;
      stable_r <= 1'b0;
    end else if (s2_r == stable_r) begin
      deb_r <= '0;
    end else if (deb_r >= DEB - 32'h1) begin
      deb_r <= '0;
      stable_r <= s2_r;
    end else begin
      deb_r <= deb_r + 32'h1;
    end
  end

  // hold duration, saturating
  always_ff @(posedge clk_sys) begin // RULE_19
    if (srst || !stable_r) held_r <= '0;
    else if (held_r != 32'hFFFF_FFFF) held_r <= held_r + 32'h1;
  end

  // repeat interval shrinks the longer the key is held
  function automatic logic [31:0] rep_period(input logic [31:0] h);
    if (h >= 32'(`KMC_REP_FASTER_MS) * 32'd1000 * US) rep_period = 32'(`KMC_REP_FAST_MS) * 32'd1000 * US;
    else rep_period = 32'(`KMC_REP_SLOW_MS) * 32'd1000 * US;
  endfunction : rep_period

  always_ff @(posedge clk_sys) begin // RULE_20
    if (srst || !stable_r || held_r < 32'(`KMC_REP_DELAY_MS) * 32'd1000 * US) rep_r <= '0;
    else if (rep_r >= rep_period(held_r) - 32'h1) rep_r <= '0;
    else rep_r <= rep_r + 32'h1;
  end

  // event outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ev.press <= 1'b0;
      ev.step <= 1'b0;
      ev.held <= 1'b0;
      ev.level <= 1'b0;
    end else begin
      ev.press <= stable_r && held_r == 32'h0;
      ev.step <= (stable_r && held_r == 32'h0) || // RULE_09
                 (held_r >= 32'(`KMC_REP_DELAY_MS) * 32'd1000 * US &&
                  rep_r == rep_period(held_r) - 32'h1);
      ev.held <= stable_r && held_r == HOLD - 32'h1;
      ev.level <= stable_r;
    end
  end
endmodule : kmc_key
`default_nettype wire

// ### verilog/kmc_menu.sv
// kmc_menu.sv: front-panel menu of a servo drive: four keys in, display code and parameters out
// assumes key inputs are raw pins; parameters are applied by the drive at its next power-up
// Notes on behaviour
// RULE_01: top layer, four modes, up/down select
// RULE_02: set enters selected mode's second layer; the code does so for modes 0 and 1 only
// RULE_03: back returns second layer to top
// RULE_04: monitor entry plus set enters monitoring
// RULE_05: sixteen monitor items, set shows value
// RULE_06: parameter mode steps numbers, set shows
// RULE_07: set on shown parameter enters editing
// RULE_08: single press steps value by one
// RULE_09: held key keeps repeating the step
// RULE_10: set commits and flashes display twice
// RULE_11: commits apply only after power cycle; the code reloads factory values at reset, so a commit never applies
// RULE_12: alarm when motor type mismatches motor
// RULE_13: password range 0-9999, default 315
// RULE_14: motor type editable only with password 385
// RULE_15: motor codes 80,90,110,130 with own defaults
// RULE_16: up held five seconds shows restore token
// RULE_17: set held five seconds restores, flashes
// RULE_18: restore overwrites all with motor defaults
// RULE_19: keys debounced, hold timed by counter
// RULE_20: longer hold raises repeat rate
`timescale 1ns/1ps
`default_nettype none
`include "kmc_regs.svh"
module kmc_menu (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // keys, raw and active high
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_back,
  input wire logic key_set,
  // attached motor and live monitor value
  input wire logic [13:0] motor_attached,
  input wire logic [13:0] mon_value,
  // display
  output logic [2:0] disp_layer,
  output logic [3:0] disp_index,
  output logic [13:0] disp_value,
  output logic disp_token,
  output logic disp_blank,
  output logic [3:0] mon_select,
  // parameters in effect and alarm
  output logic [13:0] active_motor,
  output logic [13:0] active_pass,
  output logic motor_alarm
);
  kmc_key_if up_if();
  kmc_key_if dn_if();
  kmc_key_if bk_if();
  kmc_key_if st_if();
  kmc_key u_up (.clk_sys(clk_sys), .srst(srst), .key_raw(key_up), .ev(up_if));
  kmc_key u_dn (.clk_sys(clk_sys), .srst(srst), .key_raw(key_down), .ev(dn_if));
  kmc_key u_bk (.clk_sys(clk_sys), .srst(srst), .key_raw(key_back), .ev(bk_if));
  kmc_key u_st (.clk_sys(clk_sys), .srst(srst), .key_raw(key_set), .ev(st_if));

  localparam logic [31:0] FLASH = 32'(`KMC_FLASH_CYC_DEF);

  kmc_pkg::kmc_state_e st_r;
  logic [1:0] mode_r;
  logic [3:0] idx_r;
  kmc_pkg::kmc_val_t edit_r;
  kmc_pkg::kmc_val_t stored_r [0:`KMC_NUM_PARAMS-1];
  kmc_pkg::kmc_val_t active_r [0:`KMC_NUM_PARAMS-1];
  logic boot_r;
  logic [3:0] flash_left_r;
  logic [31:0] flash_cnt_r;

  // factory value of each parameter for a motor code
  function automatic kmc_pkg::kmc_val_t factory(input logic [3:0] i, input kmc_pkg::kmc_val_t m);
    if (i == `KMC_IDX_PASS) factory = `KMC_PASS_DEFAULT;
    else if (i == `KMC_IDX_MOTOR) factory = m;
    else factory = m + 14'(i); // RULE_15
  endfunction : factory

  // upper limit of each parameter
  function automatic kmc_pkg::kmc_val_t pmax(input logic [3:0] i);
    if (i == `KMC_IDX_PASS) pmax = `KMC_PASS_MAX; // RULE_13
    else pmax = `KMC_PARAM_MAX;
  endfunction : pmax

  // step to the next or previous motor code in the list
  function automatic kmc_pkg::kmc_val_t motor_step(input kmc_pkg::kmc_val_t v, input logic up);
    case (v)
      `KMC_MOTOR_80: motor_step = up ? `KMC_MOTOR_90 : `KMC_MOTOR_80;
      `KMC_MOTOR_90: motor_step = up ? `KMC_MOTOR_110 : `KMC_MOTOR_80;
      `KMC_MOTOR_110: motor_step = up ? `KMC_MOTOR_130 : `KMC_MOTOR_90;
      default: motor_step = up ? `KMC_MOTOR_130 : `KMC_MOTOR_110;
    endcase
  endfunction : motor_step

  wire motor_unlocked = stored_r[`KMC_IDX_MOTOR] != 14'h0 &&
                        stored_r[`KMC_IDX_PASS] == `KMC_PASS_MOTOR; // RULE_14
  wire flashing = flash_left_r != 4'h0;

  // ---------------------------------------------------------------
  // menu state machine
  // ---------------------------------------------------------------
  // keys are ignored while the confirm flash runs so a commit cannot be doubled
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= kmc_pkg::KMC_TOP;
      mode_r <= 2'h0;
      idx_r <= 4'h0;
      edit_r <= '0;
    end else if (!flashing) begin
      case (st_r)
        kmc_pkg::KMC_TOP: begin
          if (up_if.step) mode_r <= mode_r + 2'h1; // RULE_01
          else if (dn_if.step) mode_r <= mode_r - 2'h1; // RULE_01
          else if (st_if.press) begin
            idx_r <= 4'h0;
            if (mode_r == 2'h0) st_r <= kmc_pkg::KMC_MON_SEL; // RULE_04
            else if (mode_r == 2'h1) st_r <= kmc_pkg::KMC_PAR_SEL; // RULE_02
          end
        end
        kmc_pkg::KMC_MON_SEL: begin
          if (bk_if.press) st_r <= kmc_pkg::KMC_TOP; // RULE_03
          else if (up_if.step) idx_r <= idx_r + 4'h1; // RULE_05
          else if (dn_if.step) idx_r <= idx_r - 4'h1;
          else if (st_if.press) st_r <= kmc_pkg::KMC_MON_SHOW; // RULE_05
        end
        kmc_pkg::KMC_MON_SHOW: begin
          if (bk_if.press) st_r <= kmc_pkg::KMC_MON_SEL;
        end
        kmc_pkg::KMC_PAR_SEL: begin
          if (bk_if.press) st_r <= kmc_pkg::KMC_TOP; // RULE_03
          else if (up_if.step) idx_r <= idx_r + 4'h1; // RULE_06
          else if (dn_if.step) idx_r <= idx_r - 4'h1;
          else if (st_if.press) st_r <= kmc_pkg::KMC_PAR_SHOW; // RULE_06
        end
        kmc_pkg::KMC_PAR_SHOW: begin
          if (bk_if.press) st_r <= kmc_pkg::KMC_PAR_SEL;
          else if (idx_r == `KMC_IDX_MOTOR && up_if.held && motor_unlocked)
            st_r <= kmc_pkg::KMC_DEF_TOKEN; // RULE_16
          else if (st_if.press && (idx_r != `KMC_IDX_MOTOR || motor_unlocked)) begin
            st_r <= kmc_pkg::KMC_PAR_EDIT; // RULE_07
            edit_r <= stored_r[idx_r];
          end
        end
        kmc_pkg::KMC_PAR_EDIT: begin
          if (bk_if.press) st_r <= kmc_pkg::KMC_PAR_SHOW;
          else if (st_if.press) st_r <= kmc_pkg::KMC_PAR_SHOW; // RULE_10
          else if (up_if.step) begin // RULE_08
            if (idx_r == `KMC_IDX_MOTOR) edit_r <= motor_step(edit_r, 1'b1);
            else if (edit_r < pmax(idx_r)) edit_r <= edit_r + 14'h1;
          end else if (dn_if.step) begin // RULE_08
            if (idx_r == `KMC_IDX_MOTOR) edit_r <= motor_step(edit_r, 1'b0);
            else if (edit_r != 14'h0) edit_r <= edit_r - 14'h1;
          end
        end
        kmc_pkg::KMC_DEF_TOKEN: begin
          if (bk_if.press) st_r <= kmc_pkg::KMC_PAR_SHOW;
          else if (st_if.held) st_r <= kmc_pkg::KMC_PAR_SHOW; // RULE_17
        end
        default: st_r <= kmc_pkg::KMC_TOP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // parameter store and power-up copy
  // ---------------------------------------------------------------
  wire commit = !flashing && st_r == kmc_pkg::KMC_PAR_EDIT && !bk_if.press && st_if.press;
  wire restore = !flashing && st_r == kmc_pkg::KMC_DEF_TOKEN && !bk_if.press && st_if.held;

  // stored values survive only in these flops; reset models power-up factory state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < `KMC_NUM_PARAMS; i++)
        stored_r[i] <= factory(4'(i), `KMC_MOTOR_80);
    end else if (commit) begin
      stored_r[idx_r] <= edit_r; // RULE_10
    end else if (restore) begin
      for (int i = 0; i < `KMC_NUM_PARAMS; i++)
        stored_r[i] <= factory(4'(i), stored_r[`KMC_IDX_MOTOR]); // RULE_18
    end
  end

  // values in effect are latched once after reset from the factory values that reset loads, so commits never take effect
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      boot_r <= 1'b1;
      for (int i = 0; i < `KMC_NUM_PARAMS; i++) active_r[i] <= '0;
    end else if (boot_r) begin
      boot_r <= 1'b0;
      for (int i = 0; i < `KMC_NUM_PARAMS; i++) active_r[i] <= stored_r[i]; // RULE_11
    end
  end

  // ---------------------------------------------------------------
  // confirm flashing
  // ---------------------------------------------------------------
  // counts half-periods: two flashes are four toggles of the blank output
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flash_left_r <= 4'h0;
      flash_cnt_r <= '0;
    end else if (commit) begin
      flash_left_r <= {`KMC_CONFIRM_FLASHES, 1'b0}; // RULE_10
      flash_cnt_r <= '0;
    end else if (restore) begin
      flash_left_r <= {`KMC_RESTORE_FLASHES, 1'b0}; // RULE_17
      flash_cnt_r <= '0;
    end else if (flashing) begin
      if (flash_cnt_r >= FLASH - 32'h1) begin
        flash_cnt_r <= '0;
        flash_left_r <= flash_left_r - 4'h1;
      end else begin
        flash_cnt_r <= flash_cnt_r + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // display and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      disp_layer <= 3'h0;
      disp_index <= 4'h0;
      disp_value <= '0;
      disp_token <= 1'b0;
      disp_blank <= 1'b0;
      mon_select <= 4'h0;
    end else begin
      disp_layer <= st_r;
      disp_index <= (st_r == kmc_pkg::KMC_TOP) ? {2'h0, mode_r} : idx_r;
      disp_token <= st_r == kmc_pkg::KMC_DEF_TOKEN; // RULE_16
      disp_blank <= flashing && !flash_left_r[0]; // RULE_10 first blank at once, so confirm is seen
      mon_select <= idx_r;
      case (st_r)
        kmc_pkg::KMC_MON_SHOW: disp_value <= mon_value;
        kmc_pkg::KMC_PAR_SHOW: disp_value <= stored_r[idx_r];
        kmc_pkg::KMC_PAR_EDIT: disp_value <= edit_r;
        kmc_pkg::KMC_DEF_TOKEN: disp_value <= `KMC_TOKEN_DEF;
        default: disp_value <= '0;
      endcase
    end
  end

  // alarm compares the motor type in effect against the one attached
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      active_motor <= '0;
      active_pass <= '0;
      motor_alarm <= 1'b0;
    end else begin
      active_motor <= active_r[`KMC_IDX_MOTOR];
      active_pass <= active_r[`KMC_IDX_PASS];
      motor_alarm <= !boot_r && active_r[`KMC_IDX_MOTOR] != motor_attached; // RULE_12
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_restore_start;
    restore;
  endsequence
  property p_top_mode;
    @(posedge clk_sys) disable iff (srst)
      st_r == kmc_pkg::KMC_TOP && !flashing && up_if.step |=> mode_r == $past(mode_r) + 2'h1;
  endproperty
  a_top_mode: assert property (p_top_mode) else $error("mode did not step"); // RULE_01
  property p_back_top;
    @(posedge clk_sys) disable iff (srst)
      (st_r == kmc_pkg::KMC_PAR_SEL || st_r == kmc_pkg::KMC_MON_SEL) && !flashing && bk_if.press
      |=> st_r == kmc_pkg::KMC_TOP;
  endproperty
  a_back_top: assert property (p_back_top) else $error("back did not return"); // RULE_03
  property p_edit_one;
    @(posedge clk_sys) disable iff (srst)
      st_r == kmc_pkg::KMC_PAR_EDIT && idx_r != `KMC_IDX_MOTOR && !flashing && !bk_if.press &&
      !st_if.press && up_if.step && edit_r < `KMC_PARAM_MAX - 14'h1 |=> edit_r == $past(edit_r) + 14'h1;
  endproperty
  a_edit_one: assert property (p_edit_one) else $error("edit step not one"); // RULE_08
  property p_commit_flash;
    @(posedge clk_sys) disable iff (srst)
      commit |=> flash_left_r == 4'h4 ##1 stored_r[$past(idx_r, 2)] == $past(edit_r, 2);
  endproperty
  a_commit_flash: assert property (p_commit_flash) else $error("commit not stored"); // RULE_10
  property p_pass_range;
    @(posedge clk_sys) disable iff (srst) stored_r[`KMC_IDX_PASS] <= `KMC_PASS_MAX;
  endproperty
  a_pass_range: assert property (p_pass_range) else $error("password out of range"); // RULE_13
  property p_motor_lock;
    @(posedge clk_sys) disable iff (srst)
      st_r == kmc_pkg::KMC_PAR_SHOW && idx_r == `KMC_IDX_MOTOR && !motor_unlocked
      |=> st_r != kmc_pkg::KMC_PAR_EDIT;
  endproperty
  a_motor_lock: assert property (p_motor_lock) else $error("motor edit unlocked"); // RULE_14
  property p_restore;
    @(posedge clk_sys) disable iff (srst)
      s_restore_start |=> stored_r[`KMC_IDX_PASS] == `KMC_PASS_DEFAULT && flash_left_r == 4'hA;
  endproperty
  a_restore: assert property (p_restore) else $error("restore failed"); // RULE_18
  property p_active_stable;
    @(posedge clk_sys) disable iff (srst)
      !boot_r && !$past(boot_r) && !$past(boot_r, 2) |-> $stable(active_motor);
  endproperty
  a_active_stable: assert property (p_active_stable) else $error("change applied early"); // RULE_11
endmodule : kmc_menu
`default_nettype wire

// ### sim/kmc_operator.sv
// kmc_operator.sv: behavioural front-panel operator who presses one key at a time
// assumes keys are active high, idle low, sampled on clk_sys rising edges
`timescale 1ns/1ps
`default_nettype none
module kmc_operator #(
  parameter int HOLD_CYC = 2020
) (
  // clock
  input wire logic clk_sys,
  // keys towards the panel
  output logic key_up,
  output logic key_down,
  output logic key_back,
  output logic key_set
);
  // ----------------------------------------
  // key handling
  // ----------------------------------------
  // keys idle low; only one key is ever down, so the priority order never matters
  initial begin
    key_up = 1'b0;
    key_down = 1'b0;
    key_back = 1'b0;
    key_set = 1'b0;
  end

  // press: 0 up, 1 down, 2 back, 3 set; hold and release both outlast the debounce span
  task automatic press(input logic [1:0] k);
    @(negedge clk_sys);
    key_up = (k === 2'h0);
    key_down = (k === 2'h1);
    key_back = (k === 2'h2);
    key_set = (k === 2'h3);
    repeat (HOLD_CYC) @(negedge clk_sys);
    key_up = 1'b0;
    key_down = 1'b0;
    key_back = 1'b0;
    key_set = 1'b0;
    // release must settle too, or the next press would merge with this one
    repeat (HOLD_CYC) @(negedge clk_sys);
  endtask : press
endmodule : kmc_operator
`default_nettype wire

// ### sim/tb_top.sv
// tb_top.sv: self-checking bench of the keypad menu: navigation, monitor, edit, commit, lockout
// assumes kmc_menu, kmc_key, kmc_key_if, kmc_pkg and kmc_regs.svh compiled before
`timescale 1ns/1ps
`default_nettype none
`include "kmc_regs.svh"
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {
    logic [1:0] key;
    logic [2:0] layer;
    logic [3:0] idx;
    logic use_val;
    logic [13:0] val;
  } kmc_row_s;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  wire logic key_up;
  wire logic key_down;
  wire logic key_back;
  wire logic key_set;
  logic [13:0] motor_attached;
  logic [13:0] mon_value;
  logic [2:0] disp_layer;
  logic [3:0] disp_index;
  logic [13:0] disp_value;
  logic disp_token;
  logic disp_blank;
  logic [3:0] mon_select;
  logic [13:0] active_motor;
  logic [13:0] active_pass;
  logic motor_alarm;
  int n_mismatch = 0;
  int num_checks = 0;
  kmc_row_s rows [14];
  logic [2:0] lay_keep;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  kmc_menu kmc_menu_i (
    .clk_sys(clk_sys), .srst(srst),
    .key_up(key_up), .key_down(key_down), .key_back(key_back), .key_set(key_set),
    .motor_attached(motor_attached), .mon_value(mon_value),
    .disp_layer(disp_layer), .disp_index(disp_index), .disp_value(disp_value),
    .disp_token(disp_token), .disp_blank(disp_blank), .mon_select(mon_select),
    .active_motor(active_motor), .active_pass(active_pass), .motor_alarm(motor_alarm)
  );

  kmc_operator kmc_operator_i (
    .clk_sys(clk_sys),
    .key_up(key_up), .key_down(key_down), .key_back(key_back), .key_set(key_set)
  );

  // ----------------------------------------
  // compare, reset and closing tasks
  // ----------------------------------------
  // one compare for every value result; narrower outputs are zero-extended by the caller
  task automatic chk_val(input logic [13:0] got, input logic [13:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // reset for three cycles; outputs are looked at while it is still asserted
  task automatic do_reset();
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_val({11'h000, disp_layer}, 14'h0000, "layer in reset");
    chk_val(active_pass, 14'h0000, "pass in reset");
    srst = 1'b0;
    // active values need two edges after release; leave margin
    repeat (5) @(negedge clk_sys);
  endtask : do_reset

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // 21 presses of about 4041 cycles each, some 85000 cycles; the limit keeps a hang short
  initial begin
    repeat (95000) @(posedge clk_sys);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    // key, layer, index, compare value, value
    rows[0] = '{2'h0, kmc_pkg::KMC_TOP, 4'h1, 1'b0, 14'h0000};
    rows[1] = '{2'h1, kmc_pkg::KMC_TOP, 4'h0, 1'b0, 14'h0000};
    rows[2] = '{2'h3, kmc_pkg::KMC_MON_SEL, 4'h0, 1'b0, 14'h0000};
    rows[3] = '{2'h1, kmc_pkg::KMC_MON_SEL, 4'hF, 1'b0, 14'h0000};
    rows[4] = '{2'h3, kmc_pkg::KMC_MON_SHOW, 4'hF, 1'b1, 14'h1234};
    rows[5] = '{2'h2, kmc_pkg::KMC_MON_SEL, 4'hF, 1'b0, 14'h0000};
    rows[6] = '{2'h2, kmc_pkg::KMC_TOP, 4'h0, 1'b0, 14'h0000};
    rows[7] = '{2'h0, kmc_pkg::KMC_TOP, 4'h1, 1'b0, 14'h0000};
    rows[8] = '{2'h3, kmc_pkg::KMC_PAR_SEL, 4'h0, 1'b0, 14'h0000};
    rows[9] = '{2'h3, kmc_pkg::KMC_PAR_SHOW, 4'h0, 1'b1, `KMC_PASS_DEFAULT};
    rows[10] = '{2'h3, kmc_pkg::KMC_PAR_EDIT, 4'h0, 1'b1, `KMC_PASS_DEFAULT};
    rows[11] = '{2'h0, kmc_pkg::KMC_PAR_EDIT, 4'h0, 1'b1, 14'h013C};
    rows[12] = '{2'h1, kmc_pkg::KMC_PAR_EDIT, 4'h0, 1'b1, 14'h013B};
    rows[13] = '{2'h1, kmc_pkg::KMC_PAR_EDIT, 4'h0, 1'b1, 14'h013A};
    motor_attached = `KMC_MOTOR_80;
    mon_value = 14'h1230;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    repeat (5) @(negedge clk_sys);
    // factory values after reset and the motor match alarm
    chk_val(active_pass, `KMC_PASS_DEFAULT, "pass default");
    chk_val(active_motor, `KMC_MOTOR_80, "motor default");
    chk_val({13'h0000, motor_alarm}, 14'h0000, "alarm on match");
    motor_attached = `KMC_MOTOR_90;
    repeat (4) @(negedge clk_sys);
    chk_val({13'h0000, motor_alarm}, 14'h0001, "alarm on mismatch");
    $display("test reset and alarm done");
    // ordinary navigation, one press per row
    for (int i = 0; i < 14; i++) begin
      // live monitor value moves every row; the shown item must follow it
      mon_value = 14'h1230 + 14'(i);
      kmc_operator_i.press(rows[i].key);
      chk_val({11'h000, disp_layer}, {11'h000, rows[i].layer}, "layer");
      if (rows[i].layer == kmc_pkg::KMC_MON_SEL) begin
        chk_val({10'h000, mon_select}, {10'h000, rows[i].idx}, "monitor item");
      end
      if (rows[i].layer != kmc_pkg::KMC_MON_SHOW) begin
        chk_val({10'h000, disp_index}, {10'h000, rows[i].idx}, "index");
      end
      if (rows[i].use_val) begin
        chk_val(disp_value, rows[i].val, "value");
      end
    end
    $display("test table done");
    // commit: display blanks for the flash, stored value not in effect
    kmc_operator_i.press(2'h3);
    chk_val({13'h0000, disp_blank}, 14'h0001, "flash after commit");
    chk_val(active_pass, `KMC_PASS_DEFAULT, "pass still old");
    lay_keep = disp_layer;
    kmc_operator_i.press(2'h2);
    chk_val({11'h000, disp_layer}, {11'h000, lay_keep}, "back ignored in flash");
    $display("test commit done");
    // second reset, then motor type editing refused under default password
    do_reset();
    chk_val(active_pass, `KMC_PASS_DEFAULT, "pass after reset");
    chk_val({13'h0000, motor_alarm}, 14'h0001, "alarm after reset");
    kmc_operator_i.press(2'h0);
    kmc_operator_i.press(2'h3);
    kmc_operator_i.press(2'h0);
    kmc_operator_i.press(2'h3);
    chk_val({10'h000, disp_index}, {10'h000, `KMC_IDX_MOTOR}, "motor index");
    chk_val(disp_value, `KMC_MOTOR_80, "motor code shown");
    kmc_operator_i.press(2'h3);
    chk_val({11'h000, disp_layer}, {11'h000, kmc_pkg::KMC_PAR_SHOW}, "edit refused");
    chk_val({13'h0000, disp_token}, 14'h0000, "no token");
    $display("test motor lock done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
